// ==== dacc_ctrl_reset.sv ====
// dacc_ctrl_reset: write-only three-wire control port, register bank and
// power-up / clock-stop sequencer of a stereo audio DAC.
// assumes clk_sys_i at 100 MHz, ctrl_clock_i as its own domain, and the
// master, frame and bit clocks arriving as unsynchronised pins.
//
// Notes on behaviour
// - stay powered down until frame clock runs
// - analog powers up 20 us after all clocks and enables
// - core and pump up after 1-2 frames
// - output valid after 1024/(os*fs) count
// - any stopped clock forces reset, grounded outputs
// - frame: chip 01, write 1, addr, data
// - data bits sampled on control clock rise
// - byte commits after sixteenth clock rise
// - ignore ones in two masked bit groups
// - timing reset keeps registers, writes still work
// - power enable low powers down, keeps registers
// - format field resets to 24-bit MSB justified
// - format field decodes five audio formats
// - auto clock select overrides manual speed
// - speed field: normal, double, quad
// - soft mute bit mutes both outputs
// - de-emphasis field resets to off
// - de-emphasis curves only in normal speed
// - roll-off bit picks slow or sharp filter
`timescale 1ns/1ps

module dacc_ctrl_reset
	import dacc_pkg::*;
#(
	parameter int unsigned FRAME_STOP_CYC = FRAME_STOP_CYC_DEF
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       ctrl_clock_i,
	input  wire logic       ctrl_select_n_i,
	input  wire logic       ctrl_data_in_i,
	input  wire logic       master_clock_i,
	input  wire logic       frame_clock_i,
	input  wire logic       bit_clock_i,
	output dacc_cfg_s       cfg_o,
	output dacc_stat_s      stat_o
);

	localparam logic [STOP_W-1:0] ANA_LAST  = STOP_W'(ANA_DELAY_CYC - 1);
	localparam logic [FCNT_W-1:0] CORE_LAST = FCNT_W'(CORE_FRAMES - 1);
	localparam logic [PIN_NUM-1:0][STOP_W-1:0] STOP_LIM = {
		STOP_W'(BICK_STOP_CYC), STOP_W'(FRAME_STOP_CYC), STOP_W'(MCLK_STOP_CYC)};
	localparam logic [REG_NUM-1:0][7:0] REG_RST = {
		RST_ATTEN, RST_ATTEN, RST_CTL_POL, RST_CTL_SPD, RST_CTL_FMT};
	localparam logic [REG_NUM-1:0][7:0] WR_MASK = {
		MASK_ALL, MASK_ALL, MASK_CTL_POL, MASK_CTL_SPD, MASK_ALL};

	function automatic dacc_speed_e spd_dec(input logic [1:0] f);
		case (f)
			SPD_DOUBLE: return SPD_DOUBLE;
			SPD_QUAD:   return SPD_QUAD;
			default:    return SPD_NORMAL;
		endcase
	endfunction : spd_dec
	function automatic logic [FCNT_W-1:0] time_a_frames(input dacc_speed_e s);
		int unsigned os;
		os = (s == SPD_QUAD) ? OS_QUAD : (s == SPD_DOUBLE) ? OS_DOUBLE : OS_NORMAL;
		return FCNT_W'(VALID_SAMPLES / os);
	endfunction : time_a_frames
	function automatic dacc_fmt_e fmt_dec(input logic [2:0] f);
		case (f)
			FMT_LSB16: return FMT_LSB16;
			FMT_LSB20: return FMT_LSB20;
			FMT_I2S24: return FMT_I2S24;
			FMT_LSB24: return FMT_LSB24;
			// undefined codes fall back to the reset format
			default:   return FMT_MSB24;
		endcase
	endfunction : fmt_dec

	////////////////////////////////////////////////////////////////////////
	// control clock domain: shift in and hold a complete frame
	logic [FRM_CNT_W-1:0] bit_cnt_reg;
	logic [FRM_BITS-2:0]  shift_reg;
	logic [FRM_BITS-1:0]  word_hold_reg;
	logic                 frm_tgl_reg;
	logic                 last_bit;

	assign last_bit = (bit_cnt_reg == FRM_CNT_W'(FRM_BITS - 1));
	// select high clears the count at once, so a short frame never commits
	always_ff @(posedge ctrl_clock_i or posedge rst_i or posedge ctrl_select_n_i) begin
		if (rst_i || ctrl_select_n_i) begin
			bit_cnt_reg <= '0;
			shift_reg   <= '0;
		end else begin
			shift_reg <= {shift_reg[FRM_BITS-3:0], ctrl_data_in_i};
			if (bit_cnt_reg != FRM_CNT_W'(FRM_BITS))
				bit_cnt_reg <= bit_cnt_reg + FRM_CNT_W'(1);
		end
	end

	// the held word changes only on a commit; it is stable long before the
	// system side sees the toggle, and the next frame is far behind
	always_ff @(posedge ctrl_clock_i or posedge rst_i) begin
		if (rst_i) begin
			word_hold_reg <= '0;
			frm_tgl_reg   <= 1'b0;
		end else if (!ctrl_select_n_i && last_bit) begin
			word_hold_reg <= {shift_reg, ctrl_data_in_i};
			frm_tgl_reg   <= ~frm_tgl_reg;
		end
	end

	chk_frame_len: assert property (@(posedge ctrl_clock_i) disable iff (rst_i)
		(frm_tgl_reg != $past(frm_tgl_reg)) |-> $past(last_bit))
		else $error("frame committed on a clock other than the sixteenth");

	////////////////////////////////////////////////////////////////////////
	// crossings into the system domain
	logic               tgl_s1_reg;
	logic               tgl_s2_reg;
	logic               tgl_s3_reg;
	logic [PIN_NUM-1:0] pin_s1_reg;
	logic [PIN_NUM-1:0] pin_s2_reg;
	logic [PIN_NUM-1:0] pin_s3_reg;
	logic               commit;
	logic [PIN_NUM-1:0] pin_edge;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			tgl_s1_reg <= 1'b0;
			tgl_s2_reg <= 1'b0;
			tgl_s3_reg <= 1'b0;
		end else begin
			tgl_s1_reg <= frm_tgl_reg;
			tgl_s2_reg <= tgl_s1_reg;
			tgl_s3_reg <= tgl_s2_reg;
		end
	end
	// master clock above 50 MHz aliases here; ratio detection assumes slower
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			pin_s3_reg <= '0;
		end else begin
			pin_s1_reg <= {bit_clock_i, frame_clock_i, master_clock_i};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	assign commit   = tgl_s2_reg ^ tgl_s3_reg;
	assign pin_edge = pin_s2_reg & ~pin_s3_reg;

	////////////////////////////////////////////////////////////////////////
	// clock presence and master/frame ratio
	logic [PIN_NUM-1:0][STOP_W-1:0] idle_cnt_reg;
	logic [PIN_NUM-1:0]             clk_run_reg;
	logic [RATIO_W-1:0]             mclk_cnt_reg;
	logic [RATIO_W-1:0]             ratio_reg;
	logic                           frame_edge;
	logic                           all_run;

	assign frame_edge = pin_edge[PIN_FRAME];
	assign all_run    = &clk_run_reg;
	// counters start saturated: every clock counts as stopped after reset
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			idle_cnt_reg <= STOP_LIM;
			clk_run_reg  <= '0;
		end else begin
			for (int i = 0; i < PIN_NUM; i++) begin
				if (pin_edge[i])
					idle_cnt_reg[i] <= '0;
				else if (idle_cnt_reg[i] != STOP_LIM[i])
					idle_cnt_reg[i] <= idle_cnt_reg[i] + STOP_W'(1);
				clk_run_reg[i] <= (idle_cnt_reg[i] != STOP_LIM[i]);
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			mclk_cnt_reg <= '0;
			ratio_reg    <= '0;
		end else if (frame_edge) begin
			ratio_reg    <= mclk_cnt_reg;
			mclk_cnt_reg <= RATIO_W'(pin_edge[PIN_MASTER]);
		end else if (pin_edge[PIN_MASTER] && !(&mclk_cnt_reg)) begin
			mclk_cnt_reg <= mclk_cnt_reg + RATIO_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register bank
	logic [REG_NUM-1:0][7:0] regs_reg;
	logic [1:0]              w_chip;
	logic                    w_rw;
	logic [4:0]              w_addr;
	logic [7:0]              w_data;
	logic                    frame_good;
	logic                    w_en;
	logic [REG_AW-1:0]       w_idx;
	logic                    reg_reset;

	assign w_chip = word_hold_reg[FRM_CHIP_HI:FRM_CHIP_LO];
	assign w_rw   = word_hold_reg[FRM_RW];
	assign w_addr = word_hold_reg[FRM_ADDR_HI:FRM_ADDR_LO];
	assign w_data = word_hold_reg[FRM_DATA_HI:FRM_DATA_LO];
	assign w_idx  = w_addr[REG_AW-1:0];

	// unknown chip, read request or address past the bank: dropped whole
	assign frame_good = (w_chip == CHIP_ADDR_VAL) && (w_rw == RW_WRITE)
		&& (w_addr < 5'(REG_NUM));
	assign w_en      = commit && frame_good;
	assign reg_reset = regs_reg[ADDR_CTL_POL][B_REG_RESET];
	// writes never look at power or timing reset, so software can set
	// everything up before it enables the part
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			regs_reg <= REG_RST;
		end else if (w_en) begin
			regs_reg[w_idx] <= w_data & WR_MASK[w_idx];
		end else if (reg_reset) begin
			regs_reg <= REG_RST;
			regs_reg[ADDR_CTL_POL][B_REG_RESET] <= 1'b1;
		end
	end

	chk_write_lands: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		w_en |=> regs_reg[$past(w_idx)] == ($past(w_data) & WR_MASK[$past(w_idx)]))
		else $error("committed byte did not reach its register");
	chk_hold_regs: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(!w_en && !reg_reset) |=> $stable(regs_reg))
		else $error("registers changed without a good frame");
	chk_masked_bits: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(regs_reg[ADDR_CTL_SPD] & ~MASK_CTL_SPD) == '0
		&& (regs_reg[ADDR_CTL_POL] & ~MASK_CTL_POL) == '0)
		else $error("an ignored bit was stored as one");

	////////////////////////////////////////////////////////////////////////
	// configuration decode
	dacc_cfg_s   cfg_reg;
	dacc_cfg_s   cfg_next;
	dacc_speed_e auto_speed;
	dacc_speed_e speed;
	logic        auto_sel;
	logic [1:0]  spd_field;

	assign auto_sel  = regs_reg[ADDR_CTL_FMT][B_AUTO_CLK];
	assign spd_field = regs_reg[ADDR_CTL_SPD][B_SPD_HI:B_SPD_LO];

	always_comb begin
		if (ratio_reg < RATIO_QUAD_MAX)
			auto_speed = SPD_QUAD;
		else if (ratio_reg < RATIO_DBL_MAX)
			auto_speed = SPD_DOUBLE;
		else
			auto_speed = SPD_NORMAL;
	end

	assign speed = auto_sel ? auto_speed : spd_dec(spd_field);
	always_comb begin
		cfg_next        = '0;
		cfg_next.fmt    = fmt_dec(regs_reg[ADDR_CTL_FMT][B_FMT_HI:B_FMT_LO]);
		cfg_next.speed  = speed;
		cfg_next.deemph = DEEMPH_OFF;
		if (speed == SPD_NORMAL)
			cfg_next.deemph = dacc_deemph_e'(regs_reg[ADDR_CTL_SPD][B_DEEMPH_HI:B_DEEMPH_LO]);
		cfg_next.soft_mute     = regs_reg[ADDR_CTL_SPD][B_MUTE];
		cfg_next.slow_rolloff  = regs_reg[ADDR_CTL_SPD][B_SLOW];
		cfg_next.invert_bit_d4 = regs_reg[ADDR_CTL_POL][B_INV_D4];
		cfg_next.invert_bit_d3 = regs_reg[ADDR_CTL_POL][B_INV_D3];
		cfg_next.atten_left    = regs_reg[ADDR_ATTEN_L];
		cfg_next.atten_right   = regs_reg[ADDR_ATTEN_R];
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			cfg_reg <= '0;
		else
			cfg_reg <= cfg_next;
	end

	assign cfg_o = cfg_reg;
	chk_deemph_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(cfg_o.speed != SPD_NORMAL) |-> (cfg_o.deemph == DEEMPH_OFF))
		else $error("de-emphasis active outside normal speed");
	chk_manual_speed: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!auto_sel |=> (cfg_o.speed == spd_dec($past(spd_field))))
		else $error("manual speed field not followed");

	////////////////////////////////////////////////////////////////////////
	// power-up and clock-stop sequencer
	dacc_state_e       state_reg;
	dacc_state_e       state_next;
	logic [STOP_W-1:0] timer_reg;
	logic [FCNT_W-1:0] fcnt_reg;
	logic [FCNT_W-1:0] valid_last;
	logic              run_ok;
	dacc_stat_s        stat_reg;
	dacc_stat_s        stat_next;

	// power and timing reset only gate the sequence, never the registers
	assign run_ok = regs_reg[ADDR_CTL_FMT][B_PWR_EN]
		&& regs_reg[ADDR_CTL_FMT][B_TIM_RST_N]
		&& all_run;
	assign valid_last = time_a_frames(cfg_reg.speed) - FCNT_W'(1);
	always_comb begin
		state_next = state_reg;
		if (!run_ok) begin
			state_next = ST_PDN;
		end else begin
			case (state_reg)
				ST_PDN: state_next = ST_ANA;
				ST_ANA: if (timer_reg == ANA_LAST) state_next = ST_CORE;
				ST_CORE: if (frame_edge && fcnt_reg == CORE_LAST) state_next = ST_CNT;
				ST_CNT: if (frame_edge && fcnt_reg == valid_last) state_next = ST_RUN;
				ST_RUN: state_next = ST_RUN;
				default: state_next = ST_PDN;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			state_reg <= ST_PDN;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			timer_reg <= '0;
		else if (state_next != state_reg)
			timer_reg <= '0;
		else if (state_reg == ST_ANA)
			timer_reg <= timer_reg + STOP_W'(1);
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			fcnt_reg <= '0;
		else if (state_next != state_reg)
			fcnt_reg <= '0;
		else if (frame_edge && (state_reg == ST_CORE || state_reg == ST_CNT))
			fcnt_reg <= fcnt_reg + FCNT_W'(1);
	end

	always_comb begin
		stat_next              = '0;
		stat_next.analog_on    = (state_next == ST_CORE) || (state_next == ST_CNT)
			|| (state_next == ST_RUN);
		stat_next.core_on      = (state_next == ST_CNT) || (state_next == ST_RUN);
		stat_next.output_valid = (state_next == ST_RUN);
		stat_next.clock_reset  = !all_run;
		stat_next.power_down   = (state_next == ST_PDN);
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			stat_reg <= '{power_down: 1'b1, clock_reset: 1'b1, default: 1'b0};
		else
			stat_reg <= stat_next;
	end

	assign stat_o = stat_reg;
	sequence s_enter_core;
		(state_reg == ST_CORE) && ($past(state_reg) == ST_ANA);
	endsequence
	sequence s_enter_cnt;
		(state_reg == ST_CNT) && ($past(state_reg) == ST_CORE);
	endsequence
	sequence s_enter_run;
		(state_reg == ST_RUN) && ($past(state_reg) == ST_CNT);
	endsequence

	chk_pdn_no_clock: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!run_ok |=> (state_reg == ST_PDN) && stat_o.power_down)
		else $error("sequencer left power-down without clocks and enables");
	chk_ground_stop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!all_run |=> (!stat_o.output_valid && !stat_o.analog_on && stat_o.clock_reset))
		else $error("outputs not grounded while a clock is stopped");
	chk_ana_delay: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_enter_core |-> ($past(timer_reg) == ANA_LAST) && stat_o.analog_on)
		else $error("analog power-up delay wrong");
	chk_core_frames: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_enter_cnt |-> ($past(fcnt_reg) == CORE_LAST) && $past(frame_edge))
		else $error("core power-up not on the second frame");
	chk_valid_time: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_enter_run |-> ($past(fcnt_reg) == $past(valid_last)) && stat_o.output_valid)
		else $error("valid output count wrong for speed");

endmodule : dacc_ctrl_reset

// ==== dacc_ctrl_reset_test.sv ====
// dacc_ctrl_reset_test: self-checking bench for the control port and sequencer.
// assumes the host model and a shortened frame-clock stop window.
`timescale 1ns/1ps
module dacc_ctrl_reset_test;
	import dacc_pkg::*;
	logic       clk_sys_i = 1'b0;
	logic       rst_i     = 1'b0;
	logic       c_clk, c_sel_n, c_dat;
	logic       mclk = 1'b0, fclk = 1'b0, bclk = 1'b0, run_m = 1'b0, run_f = 1'b0;
	dacc_cfg_s  cfg_o;
	dacc_stat_s stat_o;
	logic [7:0] regs [REG_NUM] = '{8'h8B, 8'h02, 8'h00, 8'hFF, 8'hFF};
	logic [7:0] lfsr = 8'h54;
	logic [7:0] rv;
	dacc_cfg_s  notes [$];
	event       check_ev;
	int         bad_count = 0;
	int         cmp_count = 0;
	int unsigned n;
	always #5 clk_sys_i = ~clk_sys_i;
	always #20 if (run_m) mclk = ~mclk;
	always #100 if (run_m) bclk = ~bclk;
	always #500 if (run_f) fclk = ~fclk;
	dacc_host_model host (.ctrl_clock_o(c_clk), .ctrl_select_n_o(c_sel_n),
		.ctrl_data_in_o(c_dat));
	dacc_ctrl_reset #(.FRAME_STOP_CYC(200)) DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.ctrl_clock_i(c_clk), .ctrl_select_n_i(c_sel_n), .ctrl_data_in_i(c_dat),
		.master_clock_i(mclk), .frame_clock_i(fclk), .bit_clock_i(bclk),
		.cfg_o(cfg_o), .stat_o(stat_o));
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction : rnd
	// speed under auto select is quad until frames are seen, so auto is only used then
	function automatic dacc_cfg_s exp_cfg();
		dacc_cfg_s  c;
		logic [1:0] sp;
		sp = regs[0][7] ? 2'h2 : regs[1][4:3];
		c.fmt = (regs[0][4:2] > 3'h4) ? FMT_MSB24 : dacc_fmt_e'(regs[0][4:2]);
		c.speed = (sp == 2'h3) ? SPD_NORMAL : dacc_speed_e'(sp);
		c.deemph = (c.speed == SPD_NORMAL) ? dacc_deemph_e'(regs[1][2:1]) : DEEMPH_OFF;
		c.soft_mute = regs[1][0];
		c.slow_rolloff = regs[1][5];
		c.invert_bit_d4 = regs[2][4];
		c.invert_bit_d3 = regs[2][3];
		c.atten_left = regs[3];
		c.atten_right = regs[4];
		return c;
	endfunction : exp_cfg
	task automatic wr(input logic [1:0] chip, input logic rw, input logic [2:0] a,
		input logic [7:0] d, input int unsigned nb);
		host.send({chip, rw, 2'h0, a, d}, nb);
		if (nb == 16 && chip == CHIP_ADDR_VAL && rw) begin
			regs[a] = (a == 3'h1) ? (d & MASK_CTL_SPD) : (a == 3'h2) ? (d & MASK_CTL_POL) : d;
			if (regs[2][7]) begin
				regs[0] = RST_CTL_FMT;
				regs[1] = RST_CTL_SPD;
				regs[2] = 8'h80;
				regs[3] = RST_ATTEN;
				regs[4] = RST_ATTEN;
			end
		end
		repeat (10) @(posedge clk_sys_i);
		#1;
		notes.push_back(exp_cfg());
		-> check_ev;
	endtask : wr
	task automatic wait_stat(input int unsigned b, input int unsigned lim);
		n = 0;
		while (stat_o[b] !== 1'b1 && n < lim) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
	endtask : wait_stat
	task automatic close_out();
		$display("counts: %0d compared, %0d unexpected", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////////////////
	always @(check_ev) begin
		check(cfg_o, notes.pop_front(), "cfg");
	end
	initial begin
		#1000000;
		bad_count++;
		close_out();
	end
	initial begin
		#1 rst_i = 1'b1;
		repeat (16) @(posedge clk_sys_i);
		check(stat_o, 32'h3, "stat in reset");
		// the power-on wait before the first write shrinks to the reset hold here
		#1 rst_i = 1'b0;
		repeat (3) @(posedge clk_sys_i);
		#1 notes.push_back(exp_cfg());
		-> check_ev;
		$display("done: defaults");
		for (int f = 0; f < 8; f++) begin
			wr(CHIP_ADDR_VAL, 1'b1, ADDR_CTL_FMT, {3'h0, f[2:0], 2'h3}, 16);
		end
		for (int s = 0; s < 16; s++) begin
			rv = rnd();
			wr(CHIP_ADDR_VAL, 1'b1, ADDR_CTL_SPD, {2'h3, rv[0], s[3:2], s[1:0], rv[1]}, 16);
		end
		wr(CHIP_ADDR_VAL, 1'b1, ADDR_ATTEN_L, rnd(), 16);
		wr(CHIP_ADDR_VAL, 1'b1, ADDR_ATTEN_R, rnd(), 16);
		wr(CHIP_ADDR_VAL, 1'b1, ADDR_CTL_POL, 8'h1C, 16);
		$display("done: register writes");
		wr(2'h2, 1'b1, ADDR_ATTEN_L, 8'h00, 16);
		wr(CHIP_ADDR_VAL, 1'b0, ADDR_ATTEN_L, 8'h00, 16);
		wr(CHIP_ADDR_VAL, 1'b1, ADDR_ATTEN_L, 8'h00, 15);
		wr(CHIP_ADDR_VAL, 1'b1, ADDR_CTL_POL, 8'h80, 16);
		wr(CHIP_ADDR_VAL, 1'b1, ADDR_CTL_POL, 8'h00, 16);
		$display("done: refused frames and register reset");
		wr(CHIP_ADDR_VAL, 1'b1, ADDR_CTL_FMT, 8'h0B, 16);
		wr(CHIP_ADDR_VAL, 1'b1, ADDR_CTL_SPD, 8'h02, 16);
		check(stat_o.power_down, 32'h1, "down without clocks");
		@(posedge clk_sys_i);
		#1 run_m = 1'b1;
		run_f = 1'b1;
		wait_stat(4, 3000);
		check(n >= 2000 && n < 2200, 32'h1, "analog delay");
		wait_stat(3, 1000);
		check(n >= 100 && n <= 320, 32'h1, "core delay");
		wait_stat(2, 8000);
		check(n >= 6300 && n <= 6520, 32'h1, "valid delay");
		$display("done: power-up");
		@(posedge clk_sys_i);
		#1 run_f = 1'b0;
		wait_stat(1, 500);
		check(stat_o, 32'h3, "frame clock stopped");
		@(posedge clk_sys_i);
		#1 run_f = 1'b1;
		wait_stat(4, 3000);
		check(stat_o.clock_reset, 32'h0, "clocks back");
		wr(CHIP_ADDR_VAL, 1'b1, ADDR_CTL_FMT, 8'h09, 16);
		check(stat_o, 32'h1, "power enable low");
		wr(CHIP_ADDR_VAL, 1'b1, ADDR_ATTEN_R, rnd(), 16);
		wr(CHIP_ADDR_VAL, 1'b1, ADDR_CTL_FMT, 8'h0A, 16);
		check(stat_o, 32'h1, "timing reset low");
		wr(CHIP_ADDR_VAL, 1'b1, ADDR_ATTEN_L, rnd(), 16);
		$display("done: clock stop and power control");
		close_out();
	end
endmodule : dacc_ctrl_reset_test

// ==== dacc_host_model.sv ====
// dacc_host_model: host side of the three-wire write-only control port.
// assumes the caller waits for one frame to end before it sends the next.
`timescale 1ns/1ps
module dacc_host_model (
	output logic ctrl_clock_o,
	output logic ctrl_select_n_o,
	output logic ctrl_data_in_o
);
	// 64 ns period runs the port faster than a host may, to keep the run short
	localparam time HALF_NS = 32;
	initial begin
		ctrl_clock_o    = 1'b0;
		ctrl_select_n_o = 1'b1;
		ctrl_data_in_o  = 1'b1;
	end
	// clock stands still between frames; data shows the inverse of its last bit
	// nbits below 16 ends the frame early on purpose
	task automatic send(input logic [15:0] word, input int unsigned nbits);
		if (word[12:8] < 5'h05) begin
			ctrl_select_n_o = 1'b0;
			for (int i = 0; i < nbits; i++) begin
				ctrl_data_in_o = word[15 - i];
				#HALF_NS ctrl_clock_o = 1'b1;
				#HALF_NS ctrl_clock_o = 1'b0;
			end
			ctrl_select_n_o = 1'b1;
			ctrl_data_in_o  = ~ctrl_data_in_o;
		end
	endtask : send
endmodule : dacc_host_model

// ==== dacc_pkg.sv ====
// dacc_pkg: constants, register layout and carrier types of the DAC control
// port and power/reset sequencer.
// assumes a 100 MHz system clock; every cycle count below is derived from it.
package dacc_pkg;

	localparam int unsigned SYS_CLK_NS    = 10;
	localparam int unsigned NS_PER_US     = 1000;

	// analog power-up delay, a least time: rounded up
	localparam int unsigned ANA_DELAY_US  = 20;
	localparam int unsigned ANA_DELAY_CYC = (ANA_DELAY_US * NS_PER_US + SYS_CLK_NS - 1)
		/ SYS_CLK_NS;
	// clock-stop windows, longest times: rounded down
	localparam int unsigned MCLK_STOP_NS  = 1000;
	localparam int unsigned MCLK_STOP_CYC = MCLK_STOP_NS / SYS_CLK_NS;
	localparam int unsigned BICK_STOP_NS  = 20000;
	localparam int unsigned BICK_STOP_CYC = BICK_STOP_NS / SYS_CLK_NS;
	localparam int unsigned FRAME_STOP_US = 250;
	localparam int unsigned FRAME_STOP_CYC_DEF = FRAME_STOP_US * NS_PER_US / SYS_CLK_NS;
	localparam int unsigned STOP_W        = 16;

	localparam int unsigned PIN_NUM       = 3;
	localparam int unsigned PIN_MASTER    = 0;
	localparam int unsigned PIN_FRAME     = 1;
	localparam int unsigned PIN_BIT       = 2;

	// control frame layout, first bit sent lands in the top
	localparam int unsigned FRM_BITS      = 16;
	localparam int unsigned FRM_CNT_W     = 5;
	localparam int unsigned FRM_CHIP_HI   = 15;
	localparam int unsigned FRM_CHIP_LO   = 14;
	localparam int unsigned FRM_RW        = 13;
	localparam int unsigned FRM_ADDR_HI   = 12;
	localparam int unsigned FRM_ADDR_LO   = 8;
	localparam int unsigned FRM_DATA_HI   = 7;
	localparam int unsigned FRM_DATA_LO   = 0;
	localparam logic [1:0]  CHIP_ADDR_VAL = 2'h1;
	localparam logic        RW_WRITE      = 1'h1;

	localparam int unsigned REG_NUM       = 5;
	localparam int unsigned REG_AW        = 3;
	localparam logic [2:0]  ADDR_CTL_FMT  = 3'h0;
	localparam logic [2:0]  ADDR_CTL_SPD  = 3'h1;
	localparam logic [2:0]  ADDR_CTL_POL  = 3'h2;
	localparam logic [2:0]  ADDR_ATTEN_L  = 3'h3;
	localparam logic [2:0]  ADDR_ATTEN_R  = 3'h4;

	localparam logic [7:0]  RST_CTL_FMT   = 8'h8B;
	localparam logic [7:0]  RST_CTL_SPD   = 8'h02;
	localparam logic [7:0]  RST_CTL_POL   = 8'h00;
	localparam logic [7:0]  RST_ATTEN     = 8'hFF;
	localparam logic [7:0]  MASK_ALL      = 8'hFF;
	localparam logic [7:0]  MASK_CTL_SPD  = 8'h3F;
	localparam logic [7:0]  MASK_CTL_POL  = 8'hFB;

	localparam int unsigned B_AUTO_CLK    = 7;
	localparam int unsigned B_FMT_HI      = 4;
	localparam int unsigned B_FMT_LO      = 2;
	localparam int unsigned B_PWR_EN      = 1;
	localparam int unsigned B_TIM_RST_N   = 0;
	localparam int unsigned B_SLOW        = 5;
	localparam int unsigned B_SPD_HI      = 4;
	localparam int unsigned B_SPD_LO      = 3;
	localparam int unsigned B_DEEMPH_HI   = 2;
	localparam int unsigned B_DEEMPH_LO   = 1;
	localparam int unsigned B_MUTE        = 0;
	localparam int unsigned B_REG_RESET   = 7;
	localparam int unsigned B_INV_D4      = 4;
	localparam int unsigned B_INV_D3      = 3;

	// valid-output wait: samples over oversampling factor, in frames
	localparam int unsigned VALID_SAMPLES = 1024;
	localparam int unsigned OS_NORMAL     = 16;
	localparam int unsigned OS_DOUBLE     = 8;
	localparam int unsigned OS_QUAD       = 4;
	localparam int unsigned CORE_FRAMES   = 2;
	localparam int unsigned FCNT_W        = 9;

	// master edges per frame: 128/192 quad, 256/384 double, 512 and up normal
	localparam int unsigned RATIO_W       = 11;
	localparam logic [10:0] RATIO_QUAD_MAX = 11'h0E0;
	localparam logic [10:0] RATIO_DBL_MAX  = 11'h1C0;

	typedef enum logic [2:0] {
		ST_PDN  = 3'h0,
		ST_ANA  = 3'h1,
		ST_CORE = 3'h3,
		ST_CNT  = 3'h2,
		ST_RUN  = 3'h6
	} dacc_state_e;

	typedef enum logic [1:0] {
		SPD_NORMAL = 2'h0,
		SPD_DOUBLE = 2'h1,
		SPD_QUAD   = 2'h2
	} dacc_speed_e;

	typedef enum logic [2:0] {
		FMT_LSB16 = 3'h0,
		FMT_LSB20 = 3'h1,
		FMT_MSB24 = 3'h2,
		FMT_I2S24 = 3'h3,
		FMT_LSB24 = 3'h4
	} dacc_fmt_e;

	typedef enum logic [1:0] {
		DEEMPH_441 = 2'h0,
		DEEMPH_OFF = 2'h1,
		DEEMPH_48  = 2'h2,
		DEEMPH_32  = 2'h3
	} dacc_deemph_e;

	typedef struct packed {
		dacc_fmt_e    fmt;
		dacc_speed_e  speed;
		dacc_deemph_e deemph;
		logic         soft_mute;
		logic         slow_rolloff;
		logic         invert_bit_d4;
		logic         invert_bit_d3;
		logic [7:0]   atten_left;
		logic [7:0]   atten_right;
	} dacc_cfg_s;

	typedef struct packed {
		logic analog_on;
		logic core_on;
		logic output_valid;
		logic clock_reset;
		logic power_down;
	} dacc_stat_s;

endpackage : dacc_pkg
